/* sac_regs.svh */
// constants of the smoke alarm mode control block
// assumes a 125 MHz pclk and a 10.5 ms oscillator
`ifndef SAC_REGS_SVH
`define SAC_REGS_SVH
// ****************
// register map
// ****************
`define SAC_CTRL_OFS 12'h000
`define SAC_STAT_OFS 12'h004
`define SAC_CTRL_RST 2'h1
`define SAC_CHIRP_EN_BIT 0
`define SAC_SW_TEST_BIT 1
// ****************
// timing, us
// ****************
`define SAC_PCLK_MHZ 125
`define SAC_HIGH_US 105
`define SAC_OSC_US 10505
`define SAC_PTT_US 252000
`define SAC_HALF_US 500000
`define SAC_LONG_US 1500000
`define SAC_PER_US 43000000
`define SAC_STBY_US 10000000
`define SAC_HUSH_US 600000000
`define SAC_DUMP_US 1000000
`endif

/* sac_pkg.sv */
// types of the smoke alarm mode control block
// assumes sac_regs.svh holds the numbers
package sac_pkg;
  typedef enum logic [2:0] {
    SAC_STANDBY,
    SAC_PTT,
    SAC_PTT_REL,
    SAC_HUSH,
    SAC_DIAG,
    SAC_VENDOR
  } sac_mode_e;
  typedef struct packed {
    logic degraded;
    logic low_batt;
    logic remote;
    logic local_alarm;
    logic test_alarm;
    sac_mode_e mode;
  } sac_status_s;
endpackage

/* sac_mode_ctrl.sv */
// mode and alarm sequencing of a photoelectric smoke alarm
// assumes analog comparators as levels, apb master on pclk
//
// Overview of operation
// - emitter pulse follows oscillator high phase
// - test fall restarts hush when hush enabled
// - hush lasts ten minutes, entered from test release
// - hush selects reduced smoke reference
// - push-to-test: high gain, pulse every 252ms
// - three hits: horn, line high, flash
// - failed test stays dark and silent
// - release: normal gain, three pulses, standby
// - diagnostic request held one cycle enters diag
// - diag hush picks gain and cap node
// - four hush rises with line low: vendor
// - diag feedback raises gain ten percent
// - diag follows driven oscillator levels
// - diag horn a shows smoke integrator
// - diag indicator shows low battery
// - diag pulses every cycle, strobe on
// - request released one cycle leaves diag
// - local beats remote, alarms mute chirps
// - alarm horn half second on and off
// - chamber test every 43s, chirp if degraded
// - battery check every 43s, chirp on flash
// - long horn off time 1500 ms
// - interconnect filtered by four-tick samples
// - local alarm ignores line, remote no flash
// - dump device one second after alarm
//
// Implementation choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "sac_regs.svh"
module sac_mode_ctrl #(
  parameter int HUSH_TICKS = `SAC_HUSH_US / `SAC_OSC_US
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic oscillator_node,
  input wire logic test_in,
  input wire logic diag_req,
  input wire logic hush_in,
  input wire logic io_in,
  input wire logic feedback_in,
  input wire logic smoke_det,
  input wire logic low_batt_det,
  output logic io_out,
  output logic io_oe_n,
  output logic io_dump,
  output logic emitter,
  output logic strobe,
  output logic gain_high,
  output logic gain_boost,
  output logic ref_reduced,
  output logic high_gain_cap_node,
  output logic low_gain_cap_node,
  output logic piezo_drive_a,
  output logic piezo_drive_b,
  output logic led_out,
  output logic led_oe_n
);
  localparam int PTT_T = `SAC_PTT_US / `SAC_OSC_US;
  localparam int HALF_T = `SAC_HALF_US / `SAC_OSC_US;
  localparam int LONG_T = `SAC_LONG_US / `SAC_OSC_US;
  localparam int PER_T = `SAC_PER_US / `SAC_OSC_US;
  localparam int STBY_T = `SAC_STBY_US / `SAC_OSC_US;
  localparam int DUMP_T = `SAC_DUMP_US / `SAC_OSC_US;
  localparam int PAT_T = 3 * HALF_T + 2 * HALF_T + LONG_T;
  localparam int PIN_N = 8;

  // ****************
  // pin synchronisers
  // ****************
  logic [PIN_N-1:0] pin_raw, pin_m, pin_s;
  assign pin_raw = {low_batt_det, smoke_det, feedback_in, io_in,
                    hush_in, diag_req, test_in, oscillator_node};
  genvar gi;
  generate
    for (gi = 0; gi < PIN_N; gi++)
    begin : g_sync
      // two flops per pin
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          pin_m[gi] <= 1'b0;
          pin_s[gi] <= 1'b0;
        end
        else
        begin
          pin_m[gi] <= pin_raw[gi];
          pin_s[gi] <= pin_m[gi];
        end
      end
    end
  endgenerate
  logic osc_s, diag_s, hush_s, io_s, fb_s, smoke_s, lowbat_s;
  assign osc_s = pin_s[0];
  assign diag_s = pin_s[2];
  assign hush_s = pin_s[3];
  assign io_s = pin_s[4];
  assign fb_s = pin_s[5];
  assign smoke_s = pin_s[6];
  assign lowbat_s = pin_s[7];

  // ****************
  // apb slave
  // ****************
  logic [1:0] ctrl;
  sac_pkg::sac_status_s stat;
  logic acc, hit_c, hit_s;
  assign acc = psel && penable && !pready;
  assign hit_c = paddr == `SAC_CTRL_OFS;
  assign hit_s = paddr == `SAC_STAT_OFS;
  // one wait state, unmapped gives pslverr
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl <= `SAC_CTRL_RST;
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= acc;
      pslverr <= acc && !hit_c && !hit_s;
      prdata <= 32'h0;
      if (acc && pwrite && hit_c)
        ctrl <= pwdata[1:0];
      if (acc && !pwrite && hit_c)
        prdata <= {30'h0, ctrl};
      if (acc && !pwrite && hit_s)
        prdata <= {24'h0, stat};
    end
  end

  // ****************
  // oscillator ticks
  // ****************
  logic osc_d, test_d, hush_d;
  logic tick, fall, test_any, test_fall;
  assign tick = osc_s && !osc_d;
  assign fall = !osc_s && osc_d;
  assign test_any = pin_s[1] || ctrl[`SAC_SW_TEST_BIT];
  assign test_fall = test_d && !test_any;
  // edge history
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      osc_d <= 1'b0;
      test_d <= 1'b0;
      hush_d <= 1'b0;
    end
    else
    begin
      osc_d <= osc_s;
      test_d <= test_any;
      hush_d <= hush_s;
    end
  end

  // ****************
  // mode machine
  // ****************
  sac_pkg::sac_mode_e mode;
  logic diag_like, diag_hold, hush_pend, ptt_alarm;
  logic [1:0] rel_n, ptt_hits, vend_n;
  logic [15:0] hush_cnt;
  logic pulse_act;
  assign diag_like = mode == sac_pkg::SAC_DIAG || mode == sac_pkg::SAC_VENDOR;
  // mode transitions
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode <= sac_pkg::SAC_STANDBY;
      diag_hold <= 1'b0;
      hush_pend <= 1'b0;
      hush_cnt <= 16'h0;
      rel_n <= 2'h0;
      vend_n <= 2'h0;
    end
    else
    begin
      if (tick)
        diag_hold <= diag_like ? !diag_s : diag_s;
      if (tick && diag_hold && !diag_like && diag_s)
        mode <= sac_pkg::SAC_DIAG;
      else if (tick && diag_hold && diag_like && !diag_s)
        mode <= sac_pkg::SAC_STANDBY;
      else
      begin
        case (mode)
          sac_pkg::SAC_STANDBY:
            if (tick && test_any)
              mode <= sac_pkg::SAC_PTT;
          sac_pkg::SAC_PTT:
          begin
            rel_n <= 2'h0;
            if (test_fall)
              hush_pend <= hush_s;
            if (tick && !test_any)
              mode <= sac_pkg::SAC_PTT_REL;
          end
          sac_pkg::SAC_PTT_REL:
          begin
            if (test_fall && hush_s)
              hush_pend <= 1'b1;
            if (fall && pulse_act)
              rel_n <= rel_n + 2'h1;
            if (rel_n == 2'h3)
            begin
              hush_cnt <= HUSH_TICKS[15:0];
              mode <= (hush_pend && hush_s) ? sac_pkg::SAC_HUSH
                                            : sac_pkg::SAC_STANDBY;
            end
          end
          sac_pkg::SAC_HUSH:
          begin
            if (test_fall && hush_s)
              hush_cnt <= HUSH_TICKS[15:0];
            else if (tick)
              hush_cnt <= hush_cnt - 16'h1;
            if (!hush_s)
              mode <= sac_pkg::SAC_STANDBY;
            else if (hush_cnt == 16'h0)
              mode <= sac_pkg::SAC_STANDBY;
          end
          sac_pkg::SAC_DIAG:
          begin
            if (io_s)
              vend_n <= 2'h0;
            else if (hush_s && !hush_d)
            begin
              vend_n <= vend_n + 2'h1;
              if (vend_n == 2'h3)
                mode <= sac_pkg::SAC_VENDOR;
            end
          end
          default:
            vend_n <= 2'h0;
        endcase
      end
    end
  end

  // ****************
  // emitter schedule
  // ****************
  logic [12:0] per_cnt, smp_cnt;
  logic [1:0] integ, nosmk, degr_n;
  logic local_alarm, chamb_act, degraded, low_flag;
  logic per_zero, per_half, fast, pulse_due;
  logic [12:0] smp_rel;
  assign per_zero = per_cnt == 13'h0;
  assign per_half = per_cnt == 13'(PER_T / 2);
  assign fast = mode == sac_pkg::SAC_PTT || mode == sac_pkg::SAC_PTT_REL || integ != 2'h0 || local_alarm;
  assign smp_rel = fast ? 13'(PTT_T - 1) : 13'(STBY_T - 1);
  assign pulse_due = tick && (diag_like || smp_cnt == 13'h0 || (mode != sac_pkg::SAC_PTT && per_half));
  // pulse timing and smoke evaluation
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      per_cnt <= 13'h0;
      smp_cnt <= 13'h0;
      pulse_act <= 1'b0;
      chamb_act <= 1'b0;
      integ <= 2'h0;
      nosmk <= 2'h0;
      local_alarm <= 1'b0;
      ptt_hits <= 2'h0;
      ptt_alarm <= 1'b0;
      degr_n <= 2'h0;
      degraded <= 1'b0;
      low_flag <= 1'b0;
    end
    else
    begin
      if (tick)
      begin
        per_cnt <= (per_cnt == 13'(PER_T - 1)) ? 13'h0 : per_cnt + 13'h1;
        smp_cnt <= (smp_cnt == 13'h0 || smp_cnt > smp_rel) ? smp_rel : smp_cnt - 13'h1;
        if (diag_like)
          pulse_act <= 1'b1;
        else if (smp_cnt == 13'h0)
          pulse_act <= 1'b1;
        if (!diag_like && mode != sac_pkg::SAC_PTT && per_half)
        begin
          pulse_act <= 1'b1;
          chamb_act <= 1'b1;
        end
        if (per_zero && !diag_like)
          low_flag <= lowbat_s;
      end
      if (fall && pulse_act)
      begin
        pulse_act <= 1'b0;
        chamb_act <= 1'b0;
        if (chamb_act)
        begin
          degr_n <= smoke_s ? 2'h0 : (degr_n == 2'h2 ? 2'h2 : degr_n + 2'h1);
          degraded <= !smoke_s && degr_n != 2'h0;
        end
        else if (mode == sac_pkg::SAC_PTT)
        begin
          ptt_hits <= smoke_s ? (ptt_hits == 2'h3 ? 2'h3 : ptt_hits + 2'h1) : 2'h0;
          if (smoke_s && ptt_hits == 2'h2)
            ptt_alarm <= 1'b1;
        end
        else if (mode != sac_pkg::SAC_PTT_REL)
        begin
          integ <= smoke_s ? (integ == 2'h3 ? 2'h3 : integ + 2'h1) : 2'h0;
          nosmk <= smoke_s ? 2'h0 : (nosmk == 2'h3 ? 2'h3 : nosmk + 2'h1);
          if (smoke_s && integ == 2'h2)
            local_alarm <= 1'b1;
          if (!smoke_s && nosmk == 2'h2)
            local_alarm <= 1'b0;
        end
      end
      if (mode == sac_pkg::SAC_STANDBY || diag_like)
      begin
        ptt_hits <= 2'h0;
        ptt_alarm <= 1'b0;
      end
    end
  end

  // ****************
  // interconnect filter
  // ****************
  logic [1:0] io_ph, io_hits;
  logic io_arm, remote;
  // four-tick sampling, any low clears
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      io_ph <= 2'h0;
      io_hits <= 2'h0;
      io_arm <= 1'b0;
      remote <= 1'b0;
    end
    else if (local_alarm || ptt_alarm || diag_like || !io_s)
    begin
      io_hits <= 2'h0;
      io_arm <= 1'b0;
      remote <= 1'b0;
      if (tick)
        io_ph <= io_ph + 2'h1;
    end
    else if (tick)
    begin
      io_ph <= io_ph + 2'h1;
      if (io_ph == 2'h0 && io_hits != 2'h3)
        io_hits <= io_hits + 2'h1;
      if (io_hits == 2'h3)
        io_arm <= 1'b1;
      if (io_arm)
        remote <= 1'b1;
    end
  end

  // ****************
  // horn, flash, chirp
  // ****************
  logic [8:0] pat_cnt;
  logic [9:0] fl_cnt;
  logic [6:0] dump_cnt;
  logic alarm_any, horn_on, chirp, io_drive, io_drive_d;
  logic [9:0] fl_per;
  assign alarm_any = !diag_like && (local_alarm || ptt_alarm || remote);
  assign horn_on = pat_cnt < 9'(HALF_T) || (pat_cnt >= 9'(2 * HALF_T) && pat_cnt < 9'(3 * HALF_T))
                 || (pat_cnt >= 9'(4 * HALF_T) && pat_cnt < 9'(5 * HALF_T));
  assign chirp = !alarm_any && !diag_like && ctrl[`SAC_CHIRP_EN_BIT]
               && ((per_zero && low_flag) || (per_half && degraded));
  assign io_drive = !diag_like && (local_alarm || ptt_alarm);
  assign fl_per = (mode == sac_pkg::SAC_HUSH && !alarm_any) ? 10'(STBY_T) : 10'(HALF_T);
  // pattern, flash and dump counters
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pat_cnt <= 9'h0;
      fl_cnt <= 10'h0;
      dump_cnt <= 7'h0;
      io_drive_d <= 1'b0;
    end
    else
    begin
      io_drive_d <= io_drive;
      if (!alarm_any)
        pat_cnt <= 9'h0;
      else if (tick)
        pat_cnt <= (pat_cnt == 9'(PAT_T - 1)) ? 9'h0 : pat_cnt + 9'h1;
      if (tick)
        fl_cnt <= (fl_cnt >= fl_per - 10'h1) ? 10'h0 : fl_cnt + 10'h1;
      if (io_drive_d && !io_drive)
        dump_cnt <= 7'(DUMP_T);
      else if (io_drive || diag_like)
        dump_cnt <= 7'h0;
      else if (tick && dump_cnt != 7'h0)
        dump_cnt <= dump_cnt - 7'h1;
    end
  end

  // ****************
  // output flops
  // ****************
  logic led_on, ptt_mode;
  assign ptt_mode = mode == sac_pkg::SAC_PTT || mode == sac_pkg::SAC_PTT_REL;
  always_comb
  begin
    led_on = 1'b0;
    if (diag_like)
      led_on = lowbat_s;
    else if (local_alarm || ptt_alarm)
      led_on = fl_cnt == 10'h0;
    else if (remote || ptt_mode)
      led_on = 1'b0;
    else if (mode == sac_pkg::SAC_HUSH)
      led_on = fl_cnt == 10'h0;
    else
      led_on = per_zero;
  end
  // pin drive, the emitter rides the high phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      emitter <= 1'b0;
      strobe <= 1'b0;
      gain_high <= 1'b0;
      gain_boost <= 1'b0;
      ref_reduced <= 1'b0;
      high_gain_cap_node <= 1'b0;
      low_gain_cap_node <= 1'b0;
      piezo_drive_a <= 1'b0;
      piezo_drive_b <= 1'b0;
      led_out <= 1'b0;
      led_oe_n <= 1'b1;
      io_out <= 1'b0;
      io_oe_n <= 1'b1;
      io_dump <= 1'b0;
      stat <= '0;
    end
    else
    begin
      emitter <= (pulse_act || pulse_due) && osc_s;
      strobe <= diag_like || ((pulse_act || pulse_due) && osc_s);
      gain_high <= diag_like ? (io_s && hush_s) : (mode == sac_pkg::SAC_PTT || chamb_act);
      gain_boost <= diag_like ? (io_s && !hush_s && fb_s) : local_alarm;
      ref_reduced <= mode == sac_pkg::SAC_HUSH;
      high_gain_cap_node <= diag_like && io_s && !hush_s && pulse_act;
      low_gain_cap_node <= diag_like && io_s && hush_s && pulse_act;
      piezo_drive_a <= diag_like ? local_alarm : ((alarm_any && horn_on) || (chirp && osc_s));
      piezo_drive_b <= !diag_like && ((alarm_any && horn_on) || (chirp && osc_s));
      led_out <= 1'b0;
      led_oe_n <= !led_on;
      io_out <= io_drive;
      io_oe_n <= !io_drive;
      io_dump <= dump_cnt != 7'h0;
      stat <= '{degraded: degraded, low_batt: low_flag, remote: remote,
                local_alarm: local_alarm, test_alarm: ptt_alarm, mode: mode};
    end
  end

  // ****************
  // assertions
  // ****************
  sequence s_drive_end;
    io_drive_d && !io_drive;
  endsequence
  property p_hush_gate;
    @(posedge pclk) disable iff (!presetn)
      (mode == sac_pkg::SAC_HUSH && $past(mode) != sac_pkg::SAC_HUSH) |-> $past(hush_pend && hush_s);
  endproperty
  a_hush_gate: assert property (p_hush_gate) else $error("hush entered while disabled");
  property p_hush_from;
    @(posedge pclk) disable iff (!presetn)
      $rose(mode == sac_pkg::SAC_HUSH) |-> $past(mode) == sac_pkg::SAC_PTT_REL;
  endproperty
  a_hush_from: assert property (p_hush_from) else $error("hush entered from wrong mode");
  property p_ref;
    @(posedge pclk) disable iff (!presetn)
      mode == sac_pkg::SAC_HUSH ##1 mode == sac_pkg::SAC_HUSH |-> ref_reduced;
  endproperty
  a_ref: assert property (p_ref) else $error("reduced reference missing in hush");
  property p_diag_io;
    @(posedge pclk) disable iff (!presetn)
      diag_like |-> ##1 (io_oe_n && !io_out);
  endproperty
  a_diag_io: assert property (p_diag_io) else $error("line driven in diag");
  property p_long_off;
    @(posedge pclk) disable iff (!presetn)
      (alarm_any && pat_cnt >= 9'(5 * HALF_T)) |-> ##1 !piezo_drive_b;
  endproperty
  a_long_off: assert property (p_long_off) else $error("horn on in long off");
  property p_ptt_dark;
    @(posedge pclk) disable iff (!presetn)
      (ptt_mode && !ptt_alarm && !remote && !local_alarm) |-> ##1 (led_oe_n && !piezo_drive_a && io_oe_n);
  endproperty
  a_ptt_dark: assert property (p_ptt_dark) else $error("failed test not dark");
  property p_remote;
    @(posedge pclk) disable iff (!presetn)
      $rose(remote) |-> $past(io_arm && io_s && io_hits == 2'h3);
  endproperty
  a_remote: assert property (p_remote) else $error("remote without filter");
  property p_local_first;
    @(posedge pclk) disable iff (!presetn)
      local_alarm |-> ##1 !remote;
  endproperty
  a_local_first: assert property (p_local_first) else $error("remote during local");
  property p_dump;
    @(posedge pclk) disable iff (!presetn)
      s_drive_end ##0 !diag_like |-> ##1 dump_cnt == 7'(DUMP_T) ##1 io_dump;
  endproperty
  a_dump: assert property (p_dump) else $error("dump not started");
  property p_diag_strobe;
    @(posedge pclk) disable iff (!presetn)
      diag_like ##1 diag_like |-> strobe;
  endproperty
  a_diag_strobe: assert property (p_diag_strobe) else $error("strobe off in diag");
endmodule

/* sac_peer_model.sv */
// peer detector and test fixture: oscillator source and wired interconnect
// assumes the bench sets phase lengths and peer drive at pclk edges
`timescale 1ns/1ps
module sac_peer_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] osc_high,
  input wire logic [7:0] osc_low,
  input wire logic peer_drive,
  input wire logic io_oe_n,
  output logic oscillator_node,
  output logic io_in,
  output logic tick
);
  logic [7:0] cnt;
  // oscillator driven with commanded low and high phases
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt <= 8'h00;
      oscillator_node <= 1'b0;
      tick <= 1'b0;
    end
    else
    begin
      tick <= 1'b0;
      if (cnt == 8'h00)
      begin
        oscillator_node <= !oscillator_node;
        tick <= !oscillator_node;
        cnt <= oscillator_node ? osc_low : osc_high;
      end
      else
        cnt <= cnt - 8'h01;
    end
  end
  // line with pull-down, high while any party drives it
  assign io_in = peer_drive | (io_oe_n == 1'b0);
endmodule

/* smoke_alarm_mode_control_test.sv */
// self-checking bench of the smoke alarm mode control block
// assumes sac_pkg, sac_regs.svh and sac_peer_model compiled first
`timescale 1ns/1ps
`include "sac_regs.svh"
module smoke_alarm_mode_control_test;
  localparam int HT = 20;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic test_in = 1'b0;
  logic diag_req = 1'b0;
  logic hush_in = 1'b0;
  logic feedback_in = 1'b0;
  logic smoke_det = 1'b0;
  logic low_batt_det = 1'b0;
  logic peer_drive = 1'b0;
  logic [7:0] osc_high = 8'h02;
  logic [7:0] osc_low = 8'h0C;
  logic [31:0] prdata, rd, seed;
  logic pready, pslverr, err, io_out, io_oe_n, io_dump, emitter, strobe, gain_high, gain_boost;
  logic ref_reduced, high_gain_cap_node, low_gain_cap_node, piezo_drive_a, piezo_drive_b;
  logic led_out, led_oe_n, oscillator_node, io_in, tick;
  int mismatches = 0;
  int check_count = 0;
  int i, n, w, longs;
  // ****************
  // design and far side
  // ****************
  sac_mode_ctrl #(.HUSH_TICKS(HT)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .oscillator_node(oscillator_node), .test_in(test_in), .diag_req(diag_req), .hush_in(hush_in),
    .io_in(io_in), .feedback_in(feedback_in), .smoke_det(smoke_det), .low_batt_det(low_batt_det),
    .io_out(io_out), .io_oe_n(io_oe_n), .io_dump(io_dump), .emitter(emitter), .strobe(strobe),
    .gain_high(gain_high), .gain_boost(gain_boost), .ref_reduced(ref_reduced),
    .high_gain_cap_node(high_gain_cap_node), .low_gain_cap_node(low_gain_cap_node),
    .piezo_drive_a(piezo_drive_a), .piezo_drive_b(piezo_drive_b), .led_out(led_out), .led_oe_n(led_oe_n));
  sac_peer_model u_peer (.pclk(pclk), .presetn(presetn), .osc_high(osc_high), .osc_low(osc_low),
    .peer_drive(peer_drive), .io_oe_n(io_oe_n), .oscillator_node(oscillator_node), .io_in(io_in), .tick(tick));
  // clock, 8 ns period
  always #4 pclk = ~pclk;
  // ****************
  // helpers
  // ****************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] exp_ctrl(input logic [31:0] d);
    exp_ctrl = d & 32'h3;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask
  task automatic ticks(input int k);
    repeat (k) @(posedge pclk iff tick);
    @(negedge pclk);
  endtask
  // one apb transfer, held until pready is seen
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk(32'(n < 20), 32'h1, "apb answer");
  endtask
  task automatic stat(input logic [31:0] mask, input logic [31:0] exp, input string msg);
    apb(1'b0, `SAC_STAT_OFS, 32'h0);
    chk(rd & mask, exp, msg);
  endtask
  task automatic seg(input logic v, output int c);
    c = 0;
    while (piezo_drive_a === v && c < 400)
    begin
      ticks(1);
      c++;
    end
  endtask
  task automatic pwidth(output int c);
    c = 0;
    @(posedge pclk iff emitter === 1'b1);
    while (emitter === 1'b1)
    begin
      c++;
      @(posedge pclk);
    end
    @(negedge pclk);
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // watchdog
  initial
  begin
    repeat (90000) @(posedge pclk);
    mismatches++;
    conclude();
  end
  // ****************
  // tests
  // ****************
  initial
  begin
    seed = 32'h99484b24;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk({29'h0, led_out, io_oe_n, led_oe_n}, 32'h3, "reset drives");
    apb(1'b0, `SAC_CTRL_OFS, 32'h0);
    chk(rd, 32'(`SAC_CTRL_RST), "ctrl reset");
    stat(32'h7, 32'(sac_pkg::SAC_STANDBY), "reset mode");
    seed = lfsr(seed);
    apb(1'b1, 12'h008, seed);
    chk(32'(err), 32'h1, "unmapped refused");
    apb(1'b1, `SAC_CTRL_OFS, seed & 32'h1);
    apb(1'b0, `SAC_CTRL_OFS, 32'h0);
    chk(rd, exp_ctrl(seed & 32'h1), "ctrl readback");
    apb(1'b1, `SAC_CTRL_OFS, 32'h1);
    $display("test registers done");
    // push-to-test with smoke, hush disabled
    @(posedge pclk);
    smoke_det <= 1'b1;
    test_in <= 1'b1;
    ticks(3);
    chk(32'(gain_high), 32'h1, "test gain");
    for (i = 0; i < 200 && io_oe_n !== 1'b0; i++) ticks(1);
    chk({30'h0, io_out, io_oe_n}, 32'h2, "test drives line");
    for (i = 0; i < 100 && piezo_drive_a !== 1'b1; i++) ticks(1);
    chk(32'(piezo_drive_a), 32'h1, "test horn");
    for (i = 0; i < 60 && led_oe_n !== 1'b0; i++) ticks(1);
    chk(32'(led_oe_n), 32'h0, "test flash");
    stat(32'h28, 32'h08, "own line ignored");
    @(posedge pclk);
    test_in <= 1'b0;
    smoke_det <= 1'b0;
    ticks(3);
    chk(32'(gain_high), 32'h0, "release gain");
    for (i = 0; i < 200 && io_dump !== 1'b1; i++) ticks(1);
    for (w = 0; w < 200 && io_dump === 1'b1; w++) ticks(1);
    chk(32'(w >= 90 && w <= 100), 32'h1, "dump length");
    stat(32'h7, 32'(sac_pkg::SAC_STANDBY), "no hush when disabled");
    $display("test push alarm done");
    // push-to-test without smoke, then hush
    @(posedge pclk);
    hush_in <= 1'b1;
    test_in <= 1'b1;
    ticks(100);
    chk({28'h0, io_oe_n, led_oe_n, piezo_drive_a, piezo_drive_b}, 32'hC, "failed test quiet");
    @(posedge pclk);
    test_in <= 1'b0;
    for (i = 0; i < 150 && ref_reduced !== 1'b1; i++) ticks(1);
    chk(32'(ref_reduced), 32'h1, "hush reference");
    stat(32'h7, 32'(sac_pkg::SAC_HUSH), "hush mode");
    for (w = 0; w < 100 && ref_reduced === 1'b1; w++) ticks(1);
    chk(32'(w >= HT - 3 && w <= HT + 1), 32'h1, "hush length");
    stat(32'h7, 32'(sac_pkg::SAC_STANDBY), "hush expiry");
    $display("test hush done");
    // diagnostic mode with line high
    @(posedge pclk);
    hush_in <= 1'b0;
    diag_req <= 1'b1;
    peer_drive <= 1'b1;
    ticks(4);
    stat(32'h7, 32'(sac_pkg::SAC_DIAG), "diag entry");
    chk({30'h0, io_oe_n, strobe}, 32'h3, "diag line and strobe");
    chk({30'h0, low_gain_cap_node, gain_high}, 32'h0, "diag normal gain");
    @(posedge pclk);
    feedback_in <= 1'b1;
    ticks(2);
    chk(32'(gain_boost), 32'h1, "diag boost");
    for (i = 0; i < 40 && high_gain_cap_node !== 1'b1; i++) @(posedge pclk);
    chk(32'(high_gain_cap_node), 32'h1, "high cap pulse");
    @(posedge pclk);
    feedback_in <= 1'b0;
    hush_in <= 1'b1;
    ticks(2);
    chk({30'h0, high_gain_cap_node, gain_high}, 32'h1, "diag high gain");
    @(posedge pclk);
    low_batt_det <= 1'b1;
    ticks(2);
    chk(32'(led_oe_n), 32'h0, "diag battery flag");
    @(posedge pclk);
    low_batt_det <= 1'b0;
    smoke_det <= 1'b1;
    ticks(2);
    chk({30'h0, led_oe_n, piezo_drive_a}, 32'h2, "two hits only");
    ticks(3);
    chk(32'(piezo_drive_a), 32'h1, "integrator set");
    @(posedge pclk);
    smoke_det <= 1'b0;
    ticks(2);
    chk(32'(piezo_drive_a), 32'h1, "two misses only");
    ticks(3);
    chk(32'(piezo_drive_a), 32'h0, "integrator clear");
    pwidth(w);
    chk(32'(w), 32'h3, "pulse width");
    @(posedge pclk);
    osc_high <= 8'h05;
    ticks(2);
    pwidth(w);
    chk(32'(w), 32'h6, "driven clock width");
    @(posedge pclk);
    osc_high <= 8'h02;
    diag_req <= 1'b0;
    peer_drive <= 1'b0;
    hush_in <= 1'b0;
    ticks(4);
    stat(32'h7, 32'(sac_pkg::SAC_STANDBY), "diag exit");
    // diagnostic mode with line low, hush rises lead to vendor mode
    @(posedge pclk);
    diag_req <= 1'b1;
    ticks(4);
    for (i = 0; i < 4; i++)
    begin
      if (i == 3) stat(32'h7, 32'(sac_pkg::SAC_DIAG), "three rises");
      @(posedge pclk);
      hush_in <= 1'b1;
      ticks(2);
      @(posedge pclk);
      hush_in <= 1'b0;
      ticks(2);
    end
    stat(32'h7, 32'(sac_pkg::SAC_VENDOR), "vendor entry");
    @(posedge pclk);
    diag_req <= 1'b0;
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    ticks(2);
    stat(32'h7, 32'(sac_pkg::SAC_STANDBY), "second reset");
    $display("test diagnostic done");
    // remote alarm: short glitch, then held line
    seed = lfsr(seed);
    @(posedge pclk);
    peer_drive <= 1'b1;
    ticks(1 + int'(seed[0]));
    @(posedge pclk);
    peer_drive <= 1'b0;
    ticks(20);
    stat(32'h20, 32'h0, "glitch filtered");
    @(posedge pclk);
    peer_drive <= 1'b1;
    ticks(20);
    stat(32'h30, 32'h20, "remote alarm");
    longs = 0;
    seg(1'b1, w);
    seg(1'b0, w);
    for (i = 0; i < 4; i++)
    begin
      seg(1'b1, w);
      chk(32'(w), 32'd47, "horn on");
      chk(32'(led_oe_n), 32'h1, "remote no flash");
      seg(1'b0, w);
      if (w > 100) longs++;
      chk(32'(w == 47 || w == 142), 32'h1, "horn off");
    end
    chk(32'(longs), 32'h1, "one long gap");
    @(posedge pclk);
    peer_drive <= 1'b0;
    ticks(5);
    stat(32'h20, 32'h0, "remote cleared");
    $display("test remote done");
    conclude();
  end
endmodule
